// ### src/power_ok_aggregator.sv
// Power-good aggregator: selected supply health onto a configurable pin,
// undervoltage flags with mask and interrupt, over classic Wishbone.
// Assumes the master holds requests until ack, and synchronous inputs.
//
// What this block does
// - Health drives pin only when function configured
// - Each supply counts only when selected
// - Good asserted when no selected supply undervoltage
// - Any selected undervoltage drops good unless auto switched off
// - Auto switched-off converter reports no fault
// - Buck select bits at 3:0, k at k-1
// - Buck selects reset 1,1,1 and 0
// - Linreg selects bits 9:0, reset all one
// - Every supply gives undervoltage, sets its flag
//
// The Wishbone slave port was left to the implementer.
`timescale 1ns/1ns
module power_ok_aggregator #(
  parameter int unsigned NB = pwr_ok_pkg::BUCK_COUNT,
  parameter int unsigned NL = pwr_ok_pkg::LINREG_COUNT
) (
  input wire logic clk,
  input wire logic rst_b,
  input wire logic clk_en,
  input wire logic wb_cyc_i,
  input wire logic wb_stb_i,
  input wire logic wb_we_i,
  input wire logic [pwr_ok_pkg::ADDR_W-1:0] wb_adr_i,
  input wire logic [3:0] wb_sel_i,
  input wire logic [31:0] wb_dat_i,
  output logic [31:0] wb_dat_o,
  output logic wb_ack_o,
  input wire logic [NB-1:0] buck_undervolt,
  input wire logic [NB-1:0] buck_auto_off,
  input wire logic [NL-1:0] linreg_undervolt,
  input wire logic [NL-1:0] linreg_auto_off,
  output logic supply_health_out,
  output logic supply_health_oe_b,
  output logic irq
);
  supply_if #(.N(NB)) bk ();
  supply_if #(.N(NL)) lr ();

  logic [NB-1:0] buck_monitor_sel_q, buck_monitor_sel_d;
  logic [NL-1:0] linreg_monitor_sel_q, linreg_monitor_sel_d;
  logic [NB-1:0] buck_undervolt_flag_q, buck_undervolt_flag_d;
  logic [NL-1:0] linreg_undervolt_flag_q, linreg_undervolt_flag_d;
  logic [NB-1:0] buck_mask_q, buck_mask_d;
  logic [NL-1:0] linreg_mask_q, linreg_mask_d;
  logic func_q, func_d;
  logic health_q, health_d;
  logic ack_q, ack_d;
  logic [31:0] rdata_q, rdata_d;
  logic irq_q, irq_d;
  logic req;
  logic [15:0] idx;
  logic wr_lo, wr_hi;
  logic rd_bflag, rd_lflag;

  // Supply signals into the monitor slices
  assign bk.undervolt = buck_undervolt;
  assign bk.auto_off = buck_auto_off;
  assign bk.select = buck_monitor_sel_q;
  assign lr.undervolt = linreg_undervolt;
  assign lr.auto_off = linreg_auto_off;
  assign lr.select = linreg_monitor_sel_q;

  supply_monitor #(.N(NB)) u_buck (
    .clk(clk),
    .rst_b(rst_b),
    .clk_en(clk_en),
    .sup(bk)
  );

  supply_monitor #(.N(NL)) u_linreg (
    .clk(clk),
    .rst_b(rst_b),
    .clk_en(clk_en),
    .sup(lr)
  );

  // Bus decode; single-cycle ack, dropped after one cycle while clk_en is high (held while it is low)
  assign req = wb_cyc_i & wb_stb_i & ~ack_q;
  assign idx = wb_adr_i[pwr_ok_pkg::ADDR_W-1:pwr_ok_pkg::IDX_LSB];
  assign wr_lo = req & wb_we_i & wb_sel_i[0];
  assign wr_hi = req & wb_we_i & wb_sel_i[1];
  assign rd_bflag = req & ~wb_we_i & (idx == pwr_ok_pkg::IDX_UV_BUCK_FLAGS);
  assign rd_lflag = req & ~wb_we_i & (idx == pwr_ok_pkg::IDX_UV_LINREG_FLAGS);

  // Register file next state
  always_comb begin
    buck_monitor_sel_d = buck_monitor_sel_q;
    linreg_monitor_sel_d = linreg_monitor_sel_q;
    buck_mask_d = buck_mask_q;
    linreg_mask_d = linreg_mask_q;
    func_d = func_q;
    ack_d = 1'b0;
    rdata_d = rdata_q;
    if (req) begin
      ack_d = 1'b1;
      rdata_d = 32'h0000_0000;
      case (idx)
        pwr_ok_pkg::IDX_SRC_BUCKS: begin
          if (wr_lo) buck_monitor_sel_d = wb_dat_i[NB-1:0];
          rdata_d[NB-1:0] = buck_monitor_sel_q;
        end
        pwr_ok_pkg::IDX_SRC_LINREGS: begin
          if (wr_lo) linreg_monitor_sel_d[7:0] = wb_dat_i[7:0];
          if (wr_hi) linreg_monitor_sel_d[NL-1:8] = wb_dat_i[NL-1:8];
          rdata_d[NL-1:0] = linreg_monitor_sel_q;
        end
        pwr_ok_pkg::IDX_UV_BUCK_FLAGS: rdata_d[NB-1:0] = buck_undervolt_flag_q;
        pwr_ok_pkg::IDX_UV_LINREG_FLAGS: rdata_d[NL-1:0] = linreg_undervolt_flag_q;
        pwr_ok_pkg::IDX_UV_BUCK_MASK: begin
          if (wr_lo) buck_mask_d = wb_dat_i[NB-1:0];
          rdata_d[NB-1:0] = buck_mask_q;
        end
        pwr_ok_pkg::IDX_UV_LINREG_MASK: begin
          if (wr_lo) linreg_mask_d[7:0] = wb_dat_i[7:0];
          if (wr_hi) linreg_mask_d[NL-1:8] = wb_dat_i[NL-1:8];
          rdata_d[NL-1:0] = linreg_mask_q;
        end
        pwr_ok_pkg::IDX_GPIO_FUNC: begin
          if (wr_lo) func_d = wb_dat_i[0];
          rdata_d[0] = func_q;
        end
        pwr_ok_pkg::IDX_LIVE_STATUS: begin
          rdata_d[pwr_ok_pkg::LIVE_HEALTH_BIT] = health_q;
          rdata_d[pwr_ok_pkg::LIVE_FUNC_BIT] = func_q;
        end
        default: rdata_d = 32'h0000_0000;
      endcase
    end
    if (!clk_en) begin
      buck_monitor_sel_d = buck_monitor_sel_q;
      linreg_monitor_sel_d = linreg_monitor_sel_q;
      buck_mask_d = buck_mask_q;
      linreg_mask_d = linreg_mask_q;
      func_d = func_q;
      ack_d = ack_q;
      rdata_d = rdata_q;
    end
  end

  // Sticky flags: read clears, a new edge in the same cycle wins
  always_comb begin
    buck_undervolt_flag_d = buck_undervolt_flag_q;
    linreg_undervolt_flag_d = linreg_undervolt_flag_q;
    if (clk_en) begin
      if (rd_bflag) buck_undervolt_flag_d = '0;
      if (rd_lflag) linreg_undervolt_flag_d = '0;
      buck_undervolt_flag_d = buck_undervolt_flag_d | bk.rise;
      linreg_undervolt_flag_d = linreg_undervolt_flag_d | lr.rise;
    end
  end

  // Health combination and interrupt level
  always_comb begin
    health_d = health_q;
    irq_d = irq_q;
    if (clk_en) begin
      // Empty selection leaves no fault, so good stays high
      health_d = ~(|bk.fault | |lr.fault);
      irq_d = |(buck_undervolt_flag_d & ~buck_mask_q) |
              |(linreg_undervolt_flag_d & ~linreg_mask_q);
    end
  end

  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      buck_monitor_sel_q <= pwr_ok_pkg::RST_SRC_BUCKS;
      linreg_monitor_sel_q <= pwr_ok_pkg::RST_SRC_LINREGS;
      buck_undervolt_flag_q <= '0;
      linreg_undervolt_flag_q <= '0;
      buck_mask_q <= pwr_ok_pkg::RST_BUCK_MASK;
      linreg_mask_q <= pwr_ok_pkg::RST_LINREG_MASK;
      func_q <= pwr_ok_pkg::RST_GPIO_FUNC;
      health_q <= pwr_ok_pkg::RST_HEALTH;
      ack_q <= 1'b0;
      rdata_q <= 32'h0000_0000;
      irq_q <= 1'b0;
    end else begin
      buck_monitor_sel_q <= buck_monitor_sel_d;
      linreg_monitor_sel_q <= linreg_monitor_sel_d;
      buck_undervolt_flag_q <= buck_undervolt_flag_d;
      linreg_undervolt_flag_q <= linreg_undervolt_flag_d;
      buck_mask_q <= buck_mask_d;
      linreg_mask_q <= linreg_mask_d;
      func_q <= func_d;
      health_q <= health_d;
      ack_q <= ack_d;
      rdata_q <= rdata_d;
      irq_q <= irq_d;
    end
  end

  // Pin released with output held low when unconfigured so no stale level leaks
  assign supply_health_out = func_q & health_q;
  assign supply_health_oe_b = ~func_q;
  assign wb_ack_o = ack_q;
  assign wb_dat_o = rdata_q;
  assign irq = irq_q;

  sequence s_sel_fault;
    clk_en && (|bk.fault || |lr.fault);
  endsequence

  sequence s_all_clear;
    clk_en && !(|bk.fault) && !(|lr.fault);
  endsequence

  a_fault_drops: assert property (@(posedge clk) disable iff (!rst_b)
    s_sel_fault |=> !health_q)
    else $error("health high after selected fault");
  a_clear_raises: assert property (@(posedge clk) disable iff (!rst_b)
    s_all_clear |=> health_q)
    else $error("health low with no fault");
  a_none_selected: assert property (@(posedge clk) disable iff (!rst_b)
    clk_en && buck_monitor_sel_q == '0 && linreg_monitor_sel_q == '0 |=> health_q)
    else $error("health low with empty selection");
  a_pin_gated: assert property (@(posedge clk) disable iff (!rst_b)
    !func_q |-> !supply_health_out && supply_health_oe_b)
    else $error("pin driven while unconfigured");
  a_unselected_ignored: assert property (@(posedge clk) disable iff (!rst_b)
    !buck_monitor_sel_q[0] |-> !bk.fault[0])
    else $error("unselected buck faulted");
  a_auto_off_silent: assert property (@(posedge clk) disable iff (!rst_b)
    buck_auto_off[0] |-> !bk.fault[0])
    else $error("switched-off buck faulted");
  a_flag_sets: assert property (@(posedge clk) disable iff (!rst_b)
    clk_en && lr.rise[0] |=> linreg_undervolt_flag_q[0])
    else $error("linreg flag not set");
  a_buck_write: assert property (@(posedge clk) disable iff (!rst_b)
    clk_en && wr_lo && idx == pwr_ok_pkg::IDX_SRC_BUCKS |=>
      buck_monitor_sel_q == $past(wb_dat_i[NB-1:0]))
    else $error("buck select write lost");
  a_ack_pulse: assert property (@(posedge clk) disable iff (!rst_b)
    clk_en && wb_ack_o |=> !wb_ack_o)
    else $error("ack held two cycles");
endmodule // power_ok_aggregator

// ### src/pwr_ok_pkg.sv
// Package for the power-good aggregator: register map, field layouts, resets.
// Assumes a 32-bit classic Wishbone register bus with byte addressing.
package pwr_ok_pkg;
  localparam int unsigned BUCK_COUNT = 4;
  localparam int unsigned LINREG_COUNT = 10;
  // Register indices; byte address is four times the index
  localparam logic [15:0] IDX_SRC_BUCKS = 16'h408E;
  localparam logic [15:0] IDX_SRC_LINREGS = 16'h408F;
  localparam logic [15:0] IDX_UV_BUCK_FLAGS = 16'h4090;
  localparam logic [15:0] IDX_UV_LINREG_FLAGS = 16'h4091;
  localparam logic [15:0] IDX_UV_BUCK_MASK = 16'h4092;
  localparam logic [15:0] IDX_UV_LINREG_MASK = 16'h4093;
  localparam logic [15:0] IDX_GPIO_FUNC = 16'h4094;
  localparam logic [15:0] IDX_LIVE_STATUS = 16'h4095;
  localparam int unsigned ADDR_W = 18;
  localparam int unsigned IDX_LSB = 2;
  // Reset values
  localparam logic [3:0] RST_SRC_BUCKS = 4'h7;
  localparam logic [9:0] RST_SRC_LINREGS = 10'h3FF;
  localparam logic [3:0] RST_BUCK_MASK = 4'hF;
  localparam logic [9:0] RST_LINREG_MASK = 10'h3FF;
  localparam logic RST_GPIO_FUNC = 1'b0;
  localparam logic RST_HEALTH = 1'b1;
  // Live status register field positions
  localparam int unsigned LIVE_HEALTH_BIT = 0;
  localparam int unsigned LIVE_FUNC_BIT = 1;
endpackage

// ### src/supply_if.sv
// Interface carrying supply undervoltage state between the aggregator parts.
// Assumes all users sit on one clock.
`timescale 1ns/1ns
interface supply_if #(parameter int unsigned N = 4);
  logic [N-1:0] undervolt;
  logic [N-1:0] auto_off;
  logic [N-1:0] select;
  logic [N-1:0] fault;
  logic [N-1:0] rise;
  modport monitor (input undervolt, input auto_off, input select, output fault, output rise);
  modport top (output undervolt, output auto_off, output select, input fault, input rise);
endinterface

// ### src/supply_monitor.sv
// Per-supply fault qualification and undervoltage rising-edge detection.
// Assumes undervoltage inputs are synchronous to clk.
`timescale 1ns/1ns
module supply_monitor #(
  parameter int unsigned N = 4
) (
  input wire logic clk,
  input wire logic rst_b,
  input wire logic clk_en,
  supply_if.monitor sup
);
  logic [N-1:0] prev_q;
  logic [N-1:0] prev_d;

  // Gated fault and edge detect, one slice per supply
  genvar g;
  generate
    for (g = 0; g < N; g++) begin : g_sup
      // Switched-off supply cannot pull power-good low
      assign sup.fault[g] = sup.select[g] & sup.undervolt[g] & ~sup.auto_off[g];
      assign sup.rise[g] = sup.undervolt[g] & ~prev_q[g];
    end
  endgenerate

  // Previous undervoltage level
  always_comb begin
    prev_d = clk_en ? sup.undervolt : prev_q;
  end

  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      prev_q <= '0;
    end else begin
      prev_q <= prev_d;
    end
  end

  a_rise_edge: assert property (@(posedge clk) disable iff (!rst_b)
    clk_en && sup.undervolt[0] && !$past(sup.undervolt[0]) && $past(clk_en) |-> sup.rise[0])
    else $error("rise missed on undervolt edge");
endmodule // supply_monitor

// ### testbench/host_model.sv
// Host-side model watching the power-good pad and counting falls.
// Assumes one clock shared with the device; undriven pad is pulled low.
`timescale 1ns/1ns
module host_model (
  input wire logic clk,
  input wire logic rst_b,
  input wire logic pin_out,
  input wire logic pin_oe_b,
  output logic [7:0] falls_q
);
  logic pad;
  logic pad_q;
  logic [7:0] falls_d;
  // Released pad reads the pull-down, never the last driven level
  assign pad = pin_oe_b ? 1'b0 : pin_out;
  // A fall tells software to go and fetch the undervoltage flags
  always_comb begin
    falls_d = falls_q + {7'h00, pad_q & ~pad};
  end
  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      pad_q <= 1'b0;
      falls_q <= 8'h00;
    end else begin
      pad_q <= pad;
      falls_q <= falls_d;
    end
  end
endmodule // host_model

// ### testbench/testbench.sv
// Self-checking bench: Wishbone register calls plus supply stimulus.
// Assumes the aggregator, its package and the host model are compiled first.
`timescale 1ns/1ns
module testbench;
  logic clk, rst_b, cyc, we, ack, out, oe_b, irq, ce;
  logic [17:0] adr;
  logic [31:0] wdat, rdat, rd;
  logic [3:0] buv, boff;
  logic [9:0] luv, loff;
  logic [7:0] falls;
  int n_mismatch, n_checks;

  power_ok_aggregator dut (.clk(clk), .rst_b(rst_b), .clk_en(ce), .wb_cyc_i(cyc),
    .wb_stb_i(cyc), .wb_we_i(we), .wb_adr_i(adr), .wb_sel_i(4'h3), .wb_dat_i(wdat),
    .wb_dat_o(rdat), .wb_ack_o(ack), .buck_undervolt(buv), .buck_auto_off(boff),
    .linreg_undervolt(luv), .linreg_auto_off(loff), .supply_health_out(out),
    .supply_health_oe_b(oe_b), .irq(irq));
  host_model host (.clk(clk), .rst_b(rst_b), .pin_out(out), .pin_oe_b(oe_b),
    .falls_q(falls));

  // Free-running 50 ns clock
  initial begin
    clk = 1'b0;
    forever #25 clk = ~clk;
  end

  task check(input logic [31:0] seen, input logic [31:0] exp, input string m);
    n_checks++;
    if (seen !== exp) begin
      n_mismatch++;
      $display("[FAIL] %0t %s", $time, m);
    end
  endtask

  // One classic cycle; request held until ack is sampled high
  task bus(input logic w, input logic [15:0] idx, input logic [31:0] d);
    cyc <= 1'b1;
    we <= w;
    adr <= {idx, 2'b00};
    wdat <= d;
    // Only the watchdog ends a wait that never sees ack
    do begin
      @(posedge clk);
    end while (ack !== 1'b1);
    rd = rdat;
    cyc <= 1'b0;
    we <= 1'b0;
    @(posedge clk);
  endtask

  task rchk(input logic [15:0] idx, input logic [31:0] exp, input string m);
    bus(1'b0, idx, 32'h0);
    check(rd, exp, m);
  endtask

  // Health needs one edge; two more give margin, as the pin has no flop of its own
  task pin(input logic e, input string m);
    repeat (3) @(posedge clk);
    #1;
    check({31'h0, out}, {31'h0, e}, m);
    @(posedge clk);
  endtask

  task complete_run;
    $display("checks %0d mismatches %0d", n_checks, n_mismatch);
    if (n_mismatch == 0 && n_checks > 0) begin
      $display("[ PASS ]");
    end else begin
      $display("[ FAIL ]");
    end
    $finish;
  endtask

  // Watchdog sized well past the sequence length
  initial begin
    repeat (5000) @(posedge clk);
    n_mismatch++;
    complete_run;
  end

  // Main sequence
  initial begin
    {cyc, we, adr, wdat, buv, boff, luv, loff} = '0;
    ce = 1'b1;
    n_mismatch = 0;
    n_checks = 0;
    rst_b = 1'b0;
    repeat (12) @(posedge clk);
    rst_b <= 1'b1;
    @(posedge clk);
    rchk(pwr_ok_pkg::IDX_SRC_BUCKS, 32'h7, "buck select reset");
    rchk(pwr_ok_pkg::IDX_SRC_LINREGS, 32'h3FF, "linreg select reset");
    pin(1'b0, "pin unconfigured");
    check({31'h0, oe_b}, 32'h1, "pad released");
    bus(1'b1, pwr_ok_pkg::IDX_GPIO_FUNC, 32'h1);
    pin(1'b1, "all healthy");
    check({31'h0, oe_b}, 32'h0, "pad driven");
    buv <= 4'h8;
    pin(1'b1, "unselected buck4");
    check({31'h0, irq}, 32'h0, "masked flag");
    buv <= 4'h9;
    pin(1'b0, "buck1 undervolt");
    check({24'h0, falls}, 32'h1, "host saw fall");
    rchk(pwr_ok_pkg::IDX_UV_BUCK_FLAGS, 32'h9, "buck flags");
    rchk(pwr_ok_pkg::IDX_UV_BUCK_FLAGS, 32'h0, "flags cleared");
    boff <= 4'h1;
    pin(1'b1, "auto off hides fault");
    luv <= 10'h200;
    pin(1'b0, "linreg10 undervolt");
    rchk(pwr_ok_pkg::IDX_UV_LINREG_FLAGS, 32'h200, "linreg flags");
    bus(1'b1, pwr_ok_pkg::IDX_SRC_BUCKS, 32'h0);
    bus(1'b1, pwr_ok_pkg::IDX_SRC_LINREGS, 32'h0);
    pin(1'b1, "none selected");
    rchk(pwr_ok_pkg::IDX_SRC_BUCKS, 32'h0, "buck select written");
    bus(1'b1, pwr_ok_pkg::IDX_SRC_LINREGS, 32'h200);
    pin(1'b0, "linreg10 reselected");
    bus(1'b1, pwr_ok_pkg::IDX_UV_BUCK_MASK, 32'h0);
    buv <= 4'hD;
    pin(1'b0, "still low");
    check({31'h0, irq}, 32'h1, "unmasked irq");
    rchk(pwr_ok_pkg::IDX_UV_BUCK_FLAGS, 32'h4, "buck3 flag");
    repeat (2) @(posedge clk);
    #1;
    check({31'h0, irq}, 32'h0, "irq cleared");
    @(posedge clk);
    // Enable low must freeze health while linreg10 recovers and linreg1 trips
    ce <= 1'b0;
    luv <= 10'h001;
    repeat (3) @(posedge clk);
    #1;
    check({31'h0, out}, 32'h0, "frozen by enable");
    @(posedge clk);
    ce <= 1'b1;
    pin(1'b1, "released enable");
    rchk(pwr_ok_pkg::IDX_UV_LINREG_FLAGS, 32'h1, "linreg1 flag");
    rchk(16'h4100, 32'h0, "unmapped read");
    complete_run;
  end
endmodule // testbench
